//--- core/csw_int_gate.sv
// decides which pending interrupt may start against execution priority
`timescale 1ns/1ps

module csw_int_gate
    import csw_pkg::*;
#(
    parameter int PRIO_W = CSW_PRIO_W
)
(
    input  wire logic [PRIO_W-1:0] i_exec_prio,
    input  wire logic              i_evt_pend,
    input  wire logic [PRIO_W-1:0] i_evt_prio,
    input  wire logic              i_exc_pend,
    input  wire logic              i_nmi_pend,
    output logic                   o_evt_take,
    output logic                   o_exc_take,
    output logic                   o_nmi_take
);

    logic evt_above;

    // an event must beat the running priority; the top value blocks all
    assign evt_above  = i_evt_prio > i_exec_prio;

    // exceptions and nmi ignore the execution priority
    assign o_nmi_take = i_nmi_pend;
    assign o_exc_take = i_exc_pend & ~i_nmi_pend;
    assign o_evt_take = i_evt_pend & evt_above
                        & ~i_exc_pend & ~i_nmi_pend;

endmodule

//--- core/csw_pkg.sv
// constants, field layout and types shared by the status word unit
package csw_pkg;

    ////////////////////////////////////////////////////////////////////////
    // low byte: arithmetic status flags
    localparam int CSW_C_BIT  = 7;
    localparam int CSW_AC_BIT = 6;
    localparam int CSW_V_BIT  = 2;
    localparam int CSW_N_BIT  = 1;
    localparam int CSW_Z_BIT  = 0;

    // implemented low bits; the rest are reserved and read as zero
    localparam logic [7:0] CSW_LOW_IMPL_MASK = 8'hC7;

    ////////////////////////////////////////////////////////////////////////
    // high byte: operating mode fields
    localparam int CSW_SM_BIT    = 7;
    localparam int CSW_TM_BIT    = 6;
    localparam int CSW_RS_HI_BIT = 5;
    localparam int CSW_RS_LO_BIT = 4;
    localparam int CSW_IM_MSB    = 3;
    localparam int CSW_IM_LSB    = 0;

    localparam logic [7:0] CSW_HIGH_IMPL_MASK = 8'hFF;
    // bits that user mode code may change
    localparam logic [7:0] CSW_HIGH_USER_MASK = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // values held while reset is asserted
    localparam logic [7:0] CSW_LOW_RST  = 8'h00;
    localparam logic [7:0] CSW_HIGH_RST = 8'h00;

    localparam int         CSW_PRIO_W   = 4;
    localparam int         CSW_BANKS    = 4;

    ////////////////////////////////////////////////////////////////////////
    // flag update class of the instruction that completes
    typedef enum logic [3:0] {
        CSW_OP_NONE  = 4'h0,
        CSW_OP_ADD   = 4'h1,
        CSW_OP_ADDC  = 4'h2,
        CSW_OP_SUB   = 4'h3,
        CSW_OP_SUBB  = 4'h4,
        CSW_OP_CMP   = 4'h5,
        CSW_OP_CJNE  = 4'h6,
        CSW_OP_NEG   = 4'h7,
        CSW_OP_DA    = 4'h8,
        CSW_OP_SHIFT = 4'h9,
        CSW_OP_MUL   = 4'hA,
        CSW_OP_DIV   = 4'hB,
        CSW_OP_MOVE  = 4'hC
    } csw_op_type;

endpackage

//--- core/csw_status_word.sv
// processor status word: flags, mode fields, privilege and priority
`timescale 1ns/1ps

// Operation
// - low status byte is readable and writable in user and system mode
// - high byte always readable; user writes change only bank select bits
// - carry takes carry out of the top bit for add, compare, subtract
// - shifts and rotates through carry pass the moved bit via carry
// - every multiply and divide clears carry
// - nibble carry takes low nibble carry for add, compare, subtract
// - overflow set on signed overflow of add, compare, negate, subtract
// - divide sets overflow when quotient too wide or divisor zero
// - multiply sets overflow when product exceeds source operand width
// - negative copies result sign; push, pop, extend, lea, xch keep it
// - zero set on zero result; push, pop, extend, lea, xch keep it
// - privilege bit set grants system mode, clear means user mode
// - single step trace runs only while trace bit is one
// - bank select bits pick one of four register banks
// - priority field gates event interrupts; 0 admits event priority 1 and up, 15 blocks all
// - exceptions and nmi are serviced even at top priority
// - explicit status write wins and suppresses that instruction's flags
// - write to high byte leaves low byte fully unchanged
// - after reset the word is loaded from the reset vector
module csw_status_word
    import csw_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_vec_valid,
    input  wire logic [15:0]            i_vec_word,
    input  wire logic                   i_sfr_wr_low,
    input  wire logic                   i_sfr_wr_high,
    input  wire logic [7:0]             i_sfr_wdata,
    input  wire logic                   i_alu_valid,
    input  wire csw_op_type             i_alu_op,
    input  wire logic                   i_alu_word,
    input  wire logic [15:0]            i_alu_a,
    input  wire logic [15:0]            i_alu_b,
    input  wire logic [15:0]            i_ext_result,
    input  wire logic                   i_ext_carry,
    input  wire logic                   i_div_zero,
    input  wire logic                   i_quot_ovf,
    input  wire logic                   i_mul_wide,
    input  wire logic                   i_instr_done,
    input  wire logic                   i_evt_pend,
    input  wire logic [CSW_PRIO_W-1:0]  i_evt_prio,
    input  wire logic                   i_exc_pend,
    input  wire logic                   i_nmi_pend,
    output logic      [7:0]             o_status_flags_low,
    output logic      [7:0]             o_operating_mode_high,
    output logic      [15:0]            o_alu_result,
    output logic                        o_word_loaded,
    output logic                        o_system_mode,
    output logic                        o_trace_enable,
    output logic                        o_trace_trap,
    output logic                        o_priv_denied,
    output logic      [1:0]             o_bank_select,
    output logic      [CSW_BANKS-1:0]   o_bank_enable,
    output logic                        o_evt_take,
    output logic                        o_exc_take,
    output logic                        o_nmi_take
);

    ////////////////////////////////////////////////////////////////////////
    // adder shared by add, subtract, compare and negate
    // returns {carry, nibble carry, overflow, result}
    function automatic logic [18:0] add_fn(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic        cin,
        input logic        wrd
    );
        logic [16:0] s16;
        logic [8:0]  s8;
        logic [4:0]  nib;
        logic        c;
        logic        v;
        logic [15:0] r;
        begin
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            s16 = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
            s8  = {1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
            if (wrd) begin
                c = s16[16];
                v = (a[15] == b[15]) && (s16[15] != a[15]);
                r = s16[15:0];
            end else begin
                c = s8[8];
                v = (a[7] == b[7]) && (s8[7] != a[7]);
                r = {8'h00, s8[7:0]};
            end
            add_fn = {c, nib[4], v, r};
        end
    endfunction

    // sign bit of a byte or word value
    function automatic logic sign_fn(
        input logic [15:0] val,
        input logic        wrd
    );
        sign_fn = wrd ? val[15] : val[7];
    endfunction

    // zero test of a byte or word value
    function automatic logic zero_fn(
        input logic [15:0] val,
        input logic        wrd
    );
        zero_fn = wrd ? (val == 16'h0000) : (val[7:0] == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  flags_low_r;
    logic [7:0]  mode_high_r;
    logic [15:0] alu_result_r;
    logic        loaded_r;
    logic        trace_trap_r;
    logic        priv_denied_r;

    logic [7:0]  upd_mask;
    logic [7:0]  upd_val;
    logic [15:0] res_val;
    logic [15:0] add_a;
    logic [15:0] add_b;
    logic        add_cin;
    logic        add_inv;
    logic [18:0] add_out;
    logic        c_out;
    logic        ac_out;

    logic [7:0]  low_next;
    logic [7:0]  high_next;
    logic [7:0]  high_wr_mask;
    logic        low_denied;
    logic        high_denied;
    logic        sys_mode;
    logic        explicit_wr;
    logic        alu_upd;

    assign sys_mode    = mode_high_r[CSW_SM_BIT];
    assign explicit_wr = i_sfr_wr_low | i_sfr_wr_high;
    // an explicit write to either byte drops all flag updates
    assign alu_upd     = i_alu_valid & loaded_r & ~explicit_wr;

    ////////////////////////////////////////////////////////////////////////
    // operand steering for the shared adder
    always_comb begin
        add_a   = i_alu_a;
        add_b   = i_alu_b;
        add_cin = 1'b0;
        add_inv = 1'b0;
        case (i_alu_op)
            CSW_OP_ADDC: begin
                add_cin = flags_low_r[CSW_C_BIT];
            end
            CSW_OP_SUB, CSW_OP_CMP, CSW_OP_CJNE: begin
                add_b   = ~i_alu_b;
                add_cin = 1'b1;
                add_inv = 1'b1;
            end
            CSW_OP_SUBB: begin
                add_b   = ~i_alu_b;
                add_cin = ~flags_low_r[CSW_C_BIT];
                add_inv = 1'b1;
            end
            CSW_OP_NEG: begin
                add_a   = 16'h0000;
                add_b   = ~i_alu_a;
                add_cin = 1'b1;
                add_inv = 1'b1;
            end
            default: begin
                add_a   = i_alu_a;
            end
        endcase
    end

    assign add_out = add_fn(add_a, add_b, add_cin, i_alu_word);
    // subtracts report borrow, so the raw carries are turned round
    assign c_out   = add_out[18] ^ add_inv;
    assign ac_out  = add_out[17] ^ add_inv;

    ////////////////////////////////////////////////////////////////////////
    // which flags the completing instruction updates, and to what
    always_comb begin
        upd_mask = 8'h00;
        upd_val  = 8'h00;
        res_val  = i_ext_result;
        case (i_alu_op)
            CSW_OP_ADD, CSW_OP_ADDC, CSW_OP_SUB, CSW_OP_SUBB,
            CSW_OP_CMP: begin
                res_val = add_out[15:0];
                upd_mask[CSW_C_BIT]  = 1'b1;
                upd_val[CSW_C_BIT]   = c_out;
                upd_mask[CSW_AC_BIT] = 1'b1;
                upd_val[CSW_AC_BIT]  = ac_out;
                upd_mask[CSW_V_BIT]  = 1'b1;
                upd_val[CSW_V_BIT]   = add_out[16];
            end
            CSW_OP_CJNE: begin
                res_val = add_out[15:0];
                upd_mask[CSW_C_BIT]  = 1'b1;
                upd_val[CSW_C_BIT]   = c_out;
            end
            CSW_OP_NEG: begin
                res_val = add_out[15:0];
                upd_mask[CSW_V_BIT]  = 1'b1;
                upd_val[CSW_V_BIT]   = add_out[16];
            end
            CSW_OP_DA: begin
                upd_mask[CSW_C_BIT]  = 1'b1;
                upd_val[CSW_C_BIT]   = i_ext_carry;
            end
            CSW_OP_SHIFT: begin
                // the bit shifted out lands in carry
                upd_mask[CSW_C_BIT]  = 1'b1;
                upd_val[CSW_C_BIT]   = i_ext_carry;
            end
            CSW_OP_MUL: begin
                upd_mask[CSW_C_BIT]  = 1'b1;
                upd_val[CSW_C_BIT]   = 1'b0;
                upd_mask[CSW_V_BIT]  = 1'b1;
                upd_val[CSW_V_BIT]   = i_mul_wide;
            end
            CSW_OP_DIV: begin
                upd_mask[CSW_C_BIT]  = 1'b1;
                upd_val[CSW_C_BIT]   = 1'b0;
                upd_mask[CSW_V_BIT]  = 1'b1;
                upd_val[CSW_V_BIT]   = i_quot_ovf | i_div_zero;
            end
            CSW_OP_MOVE: begin
                res_val = i_ext_result;
            end
            default: begin
                // push, pop, sign extend, lea, xch keep every flag
                res_val = i_ext_result;
            end
        endcase
        if (i_alu_op != CSW_OP_NONE) begin
            upd_mask[CSW_N_BIT] = 1'b1;
            upd_val[CSW_N_BIT]  = sign_fn(res_val, i_alu_word);
            upd_mask[CSW_Z_BIT] = 1'b1;
            upd_val[CSW_Z_BIT]  = zero_fn(res_val, i_alu_word);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // privilege filtering of explicit writes
    assign high_wr_mask = sys_mode ? CSW_HIGH_IMPL_MASK
                                   : CSW_HIGH_USER_MASK;

    csw_wr_filter u_low_filter (
        .i_cur       (flags_low_r),
        .i_wdata     (i_sfr_wdata),
        .i_wr_mask   (CSW_LOW_IMPL_MASK),
        .i_impl_mask (CSW_LOW_IMPL_MASK),
        .o_next      (low_next),
        .o_denied    (low_denied)
    );

    csw_wr_filter u_high_filter (
        .i_cur       (mode_high_r),
        .i_wdata     (i_sfr_wdata),
        .i_wr_mask   (high_wr_mask),
        .i_impl_mask (CSW_HIGH_IMPL_MASK),
        .o_next      (high_next),
        .o_denied    (high_denied)
    );

    ////////////////////////////////////////////////////////////////////////
    // reset vector load
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            loaded_r <= 1'b0;
        end else if (i_vec_valid) begin
            loaded_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low byte: vector load, then explicit write, then flag update
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_low_r <= CSW_LOW_RST;
        end else if (i_vec_valid && !loaded_r) begin
            flags_low_r <= i_vec_word[7:0] & CSW_LOW_IMPL_MASK;
        end else if (loaded_r && i_sfr_wr_low) begin
            flags_low_r <= low_next;
        end else if (alu_upd) begin
            // a high byte write alone clears alu_upd and never lands here
            flags_low_r <= (flags_low_r & ~upd_mask)
                           | (upd_val & upd_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // high byte: vector load and privilege-filtered explicit writes only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_high_r <= CSW_HIGH_RST;
        end else if (i_vec_valid && !loaded_r) begin
            mode_high_r <= i_vec_word[15:8];
        end else if (loaded_r && i_sfr_wr_high) begin
            mode_high_r <= high_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            priv_denied_r <= 1'b0;
        end else begin
            priv_denied_r <= loaded_r & i_sfr_wr_high
                             & high_denied;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result capture and single step trap
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            alu_result_r <= 16'h0000;
        end else if (i_alu_valid && loaded_r) begin
            alu_result_r <= i_alu_word ? res_val
                                       : {8'h00, res_val[7:0]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trace_trap_r <= 1'b0;
        end else begin
            trace_trap_r <= i_instr_done & loaded_r
                            & mode_high_r[CSW_TM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt gating against execution priority
    csw_int_gate #(
        .PRIO_W (CSW_PRIO_W)
    ) u_int_gate (
        .i_exec_prio (mode_high_r[CSW_IM_MSB:CSW_IM_LSB]),
        .i_evt_pend  (i_evt_pend & loaded_r),
        .i_evt_prio  (i_evt_prio),
        .i_exc_pend  (i_exc_pend),
        .i_nmi_pend  (i_nmi_pend),
        .o_evt_take  (o_evt_take),
        .o_exc_take  (o_exc_take),
        .o_nmi_take  (o_nmi_take)
    );

    ////////////////////////////////////////////////////////////////////////
    assign o_status_flags_low    = flags_low_r;
    assign o_operating_mode_high = mode_high_r;
    assign o_alu_result          = alu_result_r;
    assign o_word_loaded         = loaded_r;
    assign o_system_mode         = sys_mode;
    assign o_trace_enable        = mode_high_r[CSW_TM_BIT];
    assign o_trace_trap          = trace_trap_r;
    assign o_priv_denied         = priv_denied_r;
    assign o_bank_select         = {mode_high_r[CSW_RS_HI_BIT],
                                    mode_high_r[CSW_RS_LO_BIT]};

    // exactly one bank is reachable at a time
    always_comb begin
        o_bank_enable                = '0;
        o_bank_enable[o_bank_select] = 1'b1;
    end

    // low_denied is always zero: all implemented low bits are writable at any level
    logic unused_low_denied;
    assign unused_low_denied = low_denied;

endmodule

//--- core/csw_wr_filter.sv
// merges a written byte into a status byte under a writable-bit mask
`timescale 1ns/1ps

module csw_wr_filter
    import csw_pkg::*;
(
    input  wire logic [7:0] i_cur,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_wr_mask,
    input  wire logic [7:0] i_impl_mask,
    output logic      [7:0] o_next,
    output logic            o_denied
);

    logic [7:0] keep_mask;
    logic [7:0] blocked;

    // implemented bits outside the writable mask keep their value
    assign keep_mask = i_impl_mask & ~i_wr_mask;
    assign o_next    = ((i_cur & keep_mask)
                       | (i_wdata & i_wr_mask)) & i_impl_mask;

    // an attempt to change a protected bit is reported
    assign blocked   = (i_wdata ^ i_cur) & keep_mask;
    assign o_denied  = |blocked;

endmodule

//--- testbench/csw_status_word_props.sv
// concurrent checks on the status word unit ports, bound to its top
`timescale 1ns/1ps

module csw_status_word_props
    import csw_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_vec_valid,
    input  wire logic [15:0] i_vec_word,
    input  wire logic        i_sfr_wr_low,
    input  wire logic        i_sfr_wr_high,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_alu_valid,
    input  wire csw_op_type  i_alu_op,
    input  wire logic        i_instr_done,
    input  wire logic        i_nmi_pend,
    input  wire logic [7:0]  o_status_flags_low,
    input  wire logic [7:0]  o_operating_mode_high,
    input  wire logic        o_word_loaded,
    input  wire logic        o_system_mode,
    input  wire logic        o_trace_trap,
    input  wire logic [1:0]  o_bank_select,
    input  wire logic [3:0]  o_bank_enable,
    input  wire logic        o_evt_take,
    input  wire logic        o_nmi_take
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////
    a_user_high_locked: assert property (
        i_sfr_wr_high && o_word_loaded && !o_operating_mode_high[7] |=>
        o_operating_mode_high[7:6] == $past(o_operating_mode_high[7:6]) &&
        o_operating_mode_high[3:0] == $past(o_operating_mode_high[3:0]))
        else $error("protected high bits changed in user mode");
    a_carry_clear_muldiv: assert property (
        i_alu_valid && o_word_loaded && !i_sfr_wr_low && !i_sfr_wr_high &&
        (i_alu_op == CSW_OP_MUL || i_alu_op == CSW_OP_DIV) |=>
        !o_status_flags_low[CSW_C_BIT])
        else $error("carry not cleared by multiply or divide");
    a_system_mode_copy: assert property (
        o_system_mode == o_operating_mode_high[CSW_SM_BIT])
        else $error("system mode output differs from privilege bit");
    a_trace_trap_cause: assert property (
        o_trace_trap |-> $past(i_instr_done) &&
        $past(o_operating_mode_high[CSW_TM_BIT]))
        else $error("trace trap without instruction end and trace bit");
    a_bank_one_hot: assert property (
        o_bank_select == o_operating_mode_high[5:4] &&
        o_bank_enable == (4'h1 << o_bank_select))
        else $error("bank enable does not match bank select bits");
    a_top_prio_blocks: assert property (
        o_operating_mode_high[3:0] == 4'hF |-> !o_evt_take)
        else $error("event taken at top execution priority");
    a_nmi_always_taken: assert property (
        o_nmi_take == i_nmi_pend)
        else $error("nmi not serviced");
    a_low_write_wins: assert property (
        i_sfr_wr_low && !i_sfr_wr_high && o_word_loaded |=>
        o_status_flags_low == ($past(i_sfr_wdata) & CSW_LOW_IMPL_MASK))
        else $error("explicit low write did not take precedence");
    a_high_keeps_low: assert property (
        i_sfr_wr_high && !i_sfr_wr_low && o_word_loaded |=>
        $stable(o_status_flags_low))
        else $error("high byte write disturbed the low byte");
    a_vector_loads: assert property (
        i_vec_valid && !o_word_loaded |=> o_word_loaded &&
        {o_operating_mode_high, o_status_flags_low} ==
        ($past(i_vec_word) & {CSW_HIGH_IMPL_MASK, CSW_LOW_IMPL_MASK}))
        else $error("status word not loaded from reset vector");
    a_reserved_zero: assert property (
        o_status_flags_low[5:3] == 3'h0)
        else $error("reserved low bits not zero");

    c_vector_load: cover property (i_vec_valid && !o_word_loaded);
    c_user_write: cover property (i_sfr_wr_high && !o_system_mode);
    c_trace_trap: cover property (o_trace_trap);
endmodule

bind csw_status_word csw_status_word_props u_props (
    .i_clk, .i_rst, .i_vec_valid, .i_vec_word, .i_sfr_wr_low,
    .i_sfr_wr_high, .i_sfr_wdata, .i_alu_valid, .i_alu_op,
    .i_instr_done, .i_nmi_pend, .o_status_flags_low,
    .o_operating_mode_high, .o_word_loaded, .o_system_mode,
    .o_trace_trap, .o_bank_select, .o_bank_enable, .o_evt_take,
    .o_nmi_take
);

//--- testbench/csw_status_word_tb_top.sv
// self-checking bench for the status word unit
`timescale 1ns/1ps

module csw_status_word_tb_top
    import csw_pkg::*;
;
    typedef struct {
        csw_op_type  op;
        logic        wd;
        logic [15:0] a, b, ext;
        logic [3:0]  st;
        logic [7:0]  pre, exp;
    } csw_row_type;

    logic i_clk, i_rst, i_vec_valid, i_sfr_wr_low, i_sfr_wr_high;
    logic i_alu_valid, i_alu_word, i_ext_carry, i_div_zero, i_quot_ovf;
    logic i_mul_wide, i_instr_done, i_evt_pend, i_exc_pend, i_nmi_pend;
    logic [15:0] i_vec_word, i_alu_a, i_alu_b, i_ext_result, o_alu_result;
    logic [7:0] i_sfr_wdata, o_status_flags_low, o_operating_mode_high;
    logic [3:0] i_evt_prio, o_bank_enable;
    logic [1:0] o_bank_select;
    csw_op_type i_alu_op;
    logic o_word_loaded, o_system_mode, o_trace_enable, o_trace_trap;
    logic o_priv_denied, o_evt_take, o_exc_take, o_nmi_take;
    int n_mismatch, samples_checked;

    // st packs {ext carry, divide by zero, quotient overflow, wide product}
    csw_row_type rows [15] = '{
        '{CSW_OP_ADD,1'h0,16'h00FF,16'h0001,16'h0000,4'h0,8'h00,8'hC1},
        '{CSW_OP_ADD,1'h0,16'h007F,16'h0001,16'h0000,4'h0,8'h00,8'h46},
        '{CSW_OP_ADDC,1'h0,16'h0001,16'h0001,16'h0000,4'h0,8'h80,8'h00},
        '{CSW_OP_SUB,1'h0,16'h0000,16'h0001,16'h0000,4'h0,8'h00,8'hC2},
        '{CSW_OP_SUBB,1'h0,16'h0005,16'h0002,16'h0000,4'h0,8'h80,8'h00},
        '{CSW_OP_CMP,1'h1,16'h8000,16'h0001,16'h0000,4'h0,8'h00,8'h44},
        '{CSW_OP_CJNE,1'h0,16'h0001,16'h0002,16'h0000,4'h0,8'h00,8'h82},
        '{CSW_OP_NEG,1'h0,16'h0080,16'h0000,16'h0000,4'h0,8'hC0,8'hC6},
        '{CSW_OP_DA,1'h0,16'h0000,16'h0000,16'h0000,4'h8,8'h00,8'h81},
        '{CSW_OP_SHIFT,1'h1,16'h0000,16'h0000,16'h8000,4'h8,8'h00,8'h82},
        '{CSW_OP_MUL,1'h1,16'h0000,16'h0000,16'h0100,4'h1,8'h80,8'h04},
        '{CSW_OP_DIV,1'h1,16'h0000,16'h0000,16'h0000,4'h4,8'h80,8'h05},
        '{CSW_OP_DIV,1'h1,16'h0000,16'h0000,16'h0001,4'h2,8'hC0,8'h44},
        '{CSW_OP_MOVE,1'h0,16'h0000,16'h0000,16'h0080,4'h0,8'h00,8'h02},
        '{CSW_OP_NONE,1'h0,16'h0000,16'h0000,16'h0000,4'h0,8'hC7,8'hC7}
    };

    csw_status_word dut_u (
        .i_clk, .i_rst, .i_vec_valid, .i_vec_word, .i_sfr_wr_low,
        .i_sfr_wr_high, .i_sfr_wdata, .i_alu_valid, .i_alu_op,
        .i_alu_word, .i_alu_a, .i_alu_b, .i_ext_result, .i_ext_carry,
        .i_div_zero, .i_quot_ovf, .i_mul_wide, .i_instr_done,
        .i_evt_pend, .i_evt_prio, .i_exc_pend, .i_nmi_pend,
        .o_status_flags_low, .o_operating_mode_high, .o_alu_result,
        .o_word_loaded, .o_system_mode, .o_trace_enable, .o_trace_trap,
        .o_priv_denied, .o_bank_select, .o_bank_enable, .o_evt_take,
        .o_exc_take, .o_nmi_take
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one clock edge, then strobes drop at the falling edge
    task automatic cyc;
        @(posedge i_clk);
        @(negedge i_clk);
        {i_vec_valid, i_sfr_wr_low, i_sfr_wr_high} = 3'h0;
        {i_alu_valid, i_instr_done} = 2'h0;
    endtask

    task automatic wr(input logic hi, input logic [7:0] d);
        i_sfr_wr_high = hi;
        i_sfr_wr_low = !hi;
        i_sfr_wdata = d;
        cyc;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        {i_vec_valid, i_sfr_wr_low, i_sfr_wr_high, i_alu_valid} = 4'h0;
        {i_alu_word, i_ext_carry, i_div_zero, i_quot_ovf} = 4'h0;
        {i_mul_wide, i_instr_done, i_exc_pend, i_nmi_pend} = 4'h0;
        {i_vec_word, i_alu_a, i_alu_b, i_ext_result} = 64'h0;
        i_sfr_wdata = 8'h00;
        i_alu_op = CSW_OP_NONE;
        i_evt_pend = 1'b1;
        i_evt_prio = 4'hF;
        i_rst = 1'b1;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        chk("loaded", 16'h0, 16'(o_word_loaded));
        chk("bank_en", 16'h1, 16'(o_bank_enable));
        chk("evt_before_load", 16'h0, 16'(o_evt_take));
        i_vec_valid = 1'b1;
        i_vec_word = 16'h8FFF;
        cyc;
        chk("vec_word", 16'h8FC7, {o_operating_mode_high, o_status_flags_low});
        i_vec_valid = 1'b1;
        i_vec_word = 16'h0000;
        cyc;
        chk("vec_again", 16'h8F, 16'(o_operating_mode_high));
        i_exc_pend = 1'b1;
        #1 chk("evt_top", 16'h0, 16'(o_evt_take));
        chk("exc_top", 16'h1, 16'(o_exc_take));
        i_nmi_pend = 1'b1;
        #1 chk("nmi_top", 16'h1, 16'(o_nmi_take));
        {i_exc_pend, i_nmi_pend} = 2'h0;
        foreach (rows[k]) begin
            wr(1'b0, rows[k].pre);
            i_alu_valid = 1'b1;
            i_alu_op = rows[k].op;
            i_alu_word = rows[k].wd;
            {i_alu_a, i_alu_b, i_ext_result} = {rows[k].a, rows[k].b, rows[k].ext};
            {i_ext_carry, i_div_zero, i_quot_ovf, i_mul_wide} = rows[k].st;
            cyc;
            chk(rows[k].op.name(), 16'(rows[k].exp), 16'(o_status_flags_low));
        end
        i_alu_valid = 1'b1;
        i_alu_op = CSW_OP_MOVE;
        i_ext_result = 16'h0081;
        wr(1'b0, 8'h81);
        chk("low_wins", 16'h81, 16'(o_status_flags_low));
        chk("result", 16'h0081, o_alu_result);
        i_alu_valid = 1'b1;
        i_alu_op = CSW_OP_ADD;
        {i_alu_a, i_alu_b} = {16'h00FF, 16'h0001};
        wr(1'b1, 8'h80);
        chk("low_kept", 16'h81, 16'(o_status_flags_low));
        i_evt_prio = 4'h1;
        #1 chk("evt_open", 16'h1, 16'(o_evt_take));
        i_evt_prio = 4'h0;
        #1 chk("evt_equal", 16'h0, 16'(o_evt_take));
        for (int b = 0; b < 4; b++) begin
            wr(1'b1, 8'h80 | 8'(b << 4));
            chk("bank_sel", 16'(b), 16'(o_bank_select));
            chk("bank_en", 16'(1 << b), 16'(o_bank_enable));
        end
        wr(1'b1, 8'hC0);
        chk("trace_en", 16'h1, 16'(o_trace_enable));
        i_instr_done = 1'b1;
        cyc;
        chk("trap_on", 16'h1, 16'(o_trace_trap));
        cyc;
        chk("trap_pulse", 16'h0, 16'(o_trace_trap));
        wr(1'b1, 8'h80);
        i_instr_done = 1'b1;
        cyc;
        chk("trap_off", 16'h0, 16'(o_trace_trap));
        wr(1'b1, 8'h00);
        chk("user_mode", 16'h0, 16'(o_system_mode));
        wr(1'b1, 8'hFF);
        chk("user_high", 16'h30, 16'(o_operating_mode_high));
        chk("denied", 16'h1, 16'(o_priv_denied));
        wr(1'b0, 8'h3A);
        chk("user_low", 16'h02, 16'(o_status_flags_low));
        wrap_up;
    end
endmodule
